// ==== src/rxfwi_ident.sv ====
// Receive frame word identifier with data and broadcast frame buffers
`timescale 1ns/1ps
module rxfwi_ident
    import rxfwi_pkg::*;
(
    input  wire logic               I_REF_CLK,
    input  wire logic               I_RST_B,
    input  wire logic               i_cold_rst,
    input  wire logic               i_warm_rst,
    input  wire logic               i_remote_flush,
    input  wire logic               i_word_valid,
    input  wire logic [DATA_W-1:0]  i_word_data,
    input  wire logic               i_ctrl_valid,
    input  wire logic [3:0]         i_ctrl_type,
    input  wire logic [SEQ_W-1:0]   i_ctrl_seq_cnt,
    input  wire logic               i_ctrl_seq_pol,
    input  wire logic               i_crc_err,
    input  wire logic               i_receive_error_indication,
    input  wire logic [SEQ_W-1:0]   i_rx_seq_cnt,
    input  wire logic               i_rx_seq_pol,
    input  wire logic               i_dfrm_ready,
    output logic                    o_word_valid,
    output logic [1:0]              o_word_class,
    output logic                    o_seq_err,
    output logic                    o_dfrm_valid,
    output logic [DATA_W-1:0]       o_dfrm_data,
    output logic                    o_dfrm_last,
    output logic                    o_bcst_valid,
    output logic [DATA_W-1:0]       o_bcst_data0,
    output logic [DATA_W-1:0]       o_bcst_data1,
    output logic                    o_credit_valid,
    output logic [SEQ_W-1:0]        o_credit_seq_cnt,
    output logic                    o_ctrl_accept,
    output logic [3:0]              o_ctrl_type
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = p + PTR_ONE;
    endfunction

    function automatic logic is_cw(input logic v, input logic [3:0] t,
                                   input logic [3:0] code);
        is_cw = v && (t == code);
    endfunction

    rxfwi_state_t             state_ff;
    rxfwi_state_t             nxt_state;
    logic [BCNT_W-1:0]        bcnt_ff;
    logic [DATA_W-1:0]        dbuf_mem [DBUF_DEPTH];
    logic                     dlast_mem [DBUF_DEPTH];
    logic [PTR_W-1:0]         wptr_ff;
    logic [PTR_W-1:0]         cptr_ff;
    logic [PTR_W-1:0]         rptr_ff;
    logic                     dovf_ff;
    logic [DATA_W-1:0]        bword0_ff;
    logic [DATA_W-1:0]        bword1_ff;

    // ------------------------------------------------------------------
    // Decode of incoming control words
    // ------------------------------------------------------------------
    wire flush      = !I_RST_B || i_cold_rst || i_warm_rst || i_remote_flush;
    wire start_data_word        = is_cw(i_ctrl_valid, i_ctrl_type, CW_START_DATA);
    wire edf        = is_cw(i_ctrl_valid, i_ctrl_type, CW_END_DATA);
    wire start_broadcast_word        = is_cw(i_ctrl_valid, i_ctrl_type, CW_START_BCST);
    wire ebf        = is_cw(i_ctrl_valid, i_ctrl_type, CW_END_BCST);
    wire start_idle_word        = is_cw(i_ctrl_valid, i_ctrl_type, CW_START_IDLE);
    wire flow_credit_word        = is_cw(i_ctrl_valid, i_ctrl_type, CW_FLOW_CREDIT);
    wire retry      = is_cw(i_ctrl_valid, i_ctrl_type, CW_RETRY);
    wire receive_error_indication      = i_receive_error_indication;
    wire seq_word   = edf || ebf || flow_credit_word;
    wire [SEQ_W-1:0] seq_exp = i_rx_seq_cnt + SEQ_ONE;
    // 7-bit sum wraps modulo 128
    wire seq_err    = seq_word && ((i_ctrl_seq_cnt != seq_exp) ||
                                   (i_ctrl_seq_pol != i_rx_seq_pol));
    wire chk_err    = retry || receive_error_indication || i_crc_err || seq_err;

    wire in_data    = (state_ff == DATA_FRAME_STATE);
    wire in_bcst    = (state_ff == BROADCAST_FRAME_STATE);
    wire in_nest    = (state_ff == NESTED_BROADCAST_IN_DATA_STATE);
    wire in_idle    = (state_ff == IDLE_FRAME_STATE);

    // ------------------------------------------------------------------
    // Identification state machine
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            NO_FRAME_STATE: begin
                // End words are ignored here
                if (start_broadcast_word) begin
                    nxt_state = BROADCAST_FRAME_STATE;
                end else if (start_data_word) begin
                    nxt_state = DATA_FRAME_STATE;
                end else if (start_idle_word) begin
                    nxt_state = IDLE_FRAME_STATE;
                end
            end
            DATA_FRAME_STATE: begin
                if (chk_err) begin
                    nxt_state = NO_FRAME_STATE;
                end else if (start_broadcast_word) begin
                    nxt_state = NESTED_BROADCAST_IN_DATA_STATE;
                end else if (edf || start_data_word || start_idle_word || ebf) begin
                    nxt_state = NO_FRAME_STATE;
                end
            end
            BROADCAST_FRAME_STATE: begin
                if (chk_err) begin
                    nxt_state = NO_FRAME_STATE;
                end else if (ebf || start_data_word || start_broadcast_word || start_idle_word || edf) begin
                    nxt_state = NO_FRAME_STATE;
                end
            end
            NESTED_BROADCAST_IN_DATA_STATE: begin
                if (chk_err) begin
                    nxt_state = NO_FRAME_STATE;
                end else if (ebf && bcnt_ff == BCST_WORDS) begin
                    nxt_state = DATA_FRAME_STATE;
                end else if (ebf) begin
                    nxt_state = NO_FRAME_STATE;
                end else if (start_data_word || start_broadcast_word || start_idle_word || edf) begin
                    nxt_state = NO_FRAME_STATE;
                end
            end
            IDLE_FRAME_STATE: begin
                if (retry || receive_error_indication || edf || ebf) begin
                    nxt_state = NO_FRAME_STATE;
                end else if (start_broadcast_word) begin
                    nxt_state = BROADCAST_FRAME_STATE;
                end else if (start_data_word) begin
                    nxt_state = DATA_FRAME_STATE;
                end else if (start_idle_word) begin
                    nxt_state = IDLE_FRAME_STATE;
                end
            end
            default: begin
                nxt_state = NO_FRAME_STATE;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (flush) begin
            state_ff <= NO_FRAME_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Entry to no-frame drops uncommitted data words and clears the broadcast buffer
    wire enter_none = (nxt_state == NO_FRAME_STATE) && (state_ff != NO_FRAME_STATE);

    // ------------------------------------------------------------------
    // Word classification and broadcast word count
    // ------------------------------------------------------------------
    wire bcst_word = i_word_valid && (in_bcst || in_nest);
    wire [1:0] cls = in_data ? WCLS_DATA :
                     (in_bcst || in_nest) ? WCLS_BCST :
                     in_idle ? WCLS_IDLE : WCLS_NONE;
    // Saturates, never wrapping back to zero
    wire bcnt_sat  = (bcnt_ff == {BCNT_W{1'b1}});

    always_ff @(posedge I_REF_CLK) begin
        if (flush) begin
            o_word_valid <= 1'b0;
            o_word_class <= WCLS_NONE;
            o_seq_err    <= 1'b0;
            bcnt_ff      <= '0;
        end else begin
            o_word_valid <= i_word_valid;
            o_word_class <= cls;
            o_seq_err    <= seq_err;
            if (start_broadcast_word) begin
                bcnt_ff <= '0;
            end else if (bcst_word && !bcnt_sat) begin
                bcnt_ff <= bcnt_ff + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Data frame buffer: words up to the commit pointer are released
    // ------------------------------------------------------------------
    wire [PTR_W-1:0] dfill  = wptr_ff - rptr_ff;
    wire dfull      = (dfill == DBUF_FULL);
    wire dword      = i_word_valid && in_data;
    wire dwr        = dword && !dfull;
    // Overflowed or empty frames never commit
    wire dcommit    = in_data && edf && !chk_err && !dovf_ff &&
                      (wptr_ff != cptr_ff);
    wire dflush     = start_data_word || enter_none;
    wire dpop       = o_dfrm_valid && i_dfrm_ready;
    wire [DBUF_AW-1:0] last_idx = DBUF_AW'(wptr_ff - PTR_ONE);

    // Only committed words are visible to the framing layer
    assign o_dfrm_valid = (rptr_ff != cptr_ff);
    assign o_dfrm_data  = dbuf_mem[rptr_ff[DBUF_AW-1:0]];
    assign o_dfrm_last  = dlast_mem[rptr_ff[DBUF_AW-1:0]];

    always_ff @(posedge I_REF_CLK) begin
        if (dwr) begin
            dbuf_mem[wptr_ff[DBUF_AW-1:0]]  <= i_word_data;
            dlast_mem[wptr_ff[DBUF_AW-1:0]] <= 1'b0;
        end
        // Last mark lands beside a new word too
        if (dcommit) begin
            dlast_mem[last_idx] <= 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (flush) begin
            wptr_ff <= PTR_ZERO;
            cptr_ff <= PTR_ZERO;
            rptr_ff <= PTR_ZERO;
            dovf_ff <= 1'b0;
        end else begin
            if (dpop) begin
                rptr_ff <= ptr_inc(rptr_ff);
            end
            // A word beside the end word is left out
            if (dcommit) begin
                cptr_ff <= wptr_ff;
                dovf_ff <= 1'b0;
            end else if (dflush) begin
                // Uncommitted words are dropped
                wptr_ff <= cptr_ff;
                dovf_ff <= 1'b0;
            end else if (dwr) begin
                wptr_ff <= ptr_inc(wptr_ff);
            end else if (dword) begin
                // Full: frame dropped at its end word
                dovf_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Broadcast buffer and its release
    // ------------------------------------------------------------------
    wire bflush = start_broadcast_word || enter_none;
    wire bgood  = (in_bcst || in_nest) && ebf && !chk_err &&
                  (bcnt_ff == BCST_WORDS);

    always_ff @(posedge I_REF_CLK) begin
        if (flush || bflush) begin
            bword0_ff <= '0;
            bword1_ff <= '0;
        end else if (bcst_word) begin
            if (bcnt_ff == 3'h0) begin
                bword0_ff <= i_word_data;
            end else if (bcnt_ff == 3'h1) begin
                bword1_ff <= i_word_data;
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (flush) begin
            o_bcst_valid <= 1'b0;
            o_bcst_data0 <= '0;
            o_bcst_data1 <= '0;
        end else begin
            o_bcst_valid <= bgood;
            if (bgood) begin
                o_bcst_data0 <= bword0_ff;
                o_bcst_data1 <= bword1_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control words accepted in any state
    // ------------------------------------------------------------------
    // Only clean, in-sequence credits pass
    wire credit_ok = flow_credit_word && !i_crc_err && !seq_err && !receive_error_indication;
    wire ack_like  = i_ctrl_valid && ((i_ctrl_type == CW_ACK) ||
                     (i_ctrl_type == CW_NACK) || (i_ctrl_type == CW_NO_SPACE) ||
                     (i_ctrl_type == CW_RETRY) || (i_ctrl_type == CW_FLOW_CREDIT));

    always_ff @(posedge I_REF_CLK) begin
        if (flush) begin
            o_credit_valid   <= 1'b0;
            o_credit_seq_cnt <= '0;
            o_ctrl_accept    <= 1'b0;
            o_ctrl_type      <= 4'h0;
        end else begin
            o_credit_valid <= credit_ok;
            o_ctrl_accept  <= ack_like;
            if (credit_ok) begin
                o_credit_seq_cnt <= i_ctrl_seq_cnt;
            end
            if (ack_like) begin
                o_ctrl_type <= i_ctrl_type;
            end
        end
    end

endmodule

// ==== src/rxfwi_pkg.sv ====
// Constants, codes and state type of the receive frame word identifier
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package rxfwi_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int          DATA_W      = 32;
    localparam int          DBUF_AW     = 6;
    localparam int          DBUF_DEPTH  = 64;
    localparam int          PTR_W       = DBUF_AW + 1;
    localparam int          SEQ_W       = 7;
    localparam int          BCNT_W      = 3;
    localparam logic [2:0]  BCST_WORDS  = 3'h2;
    localparam logic [6:0]  PTR_ZERO    = 7'h00;
    localparam logic [6:0]  PTR_ONE     = 7'h01;
    localparam logic [6:0]  DBUF_FULL   = 7'h40;
    localparam logic [6:0]  SEQ_ONE     = 7'h01;

    // ------------------------------------------------------------------
    // Control word codes from the lane layer
    // ------------------------------------------------------------------
    localparam logic [3:0]  CW_START_DATA  = 4'h1;
    localparam logic [3:0]  CW_END_DATA    = 4'h2;
    localparam logic [3:0]  CW_START_BCST  = 4'h3;
    localparam logic [3:0]  CW_END_BCST    = 4'h4;
    localparam logic [3:0]  CW_START_IDLE  = 4'h5;
    localparam logic [3:0]  CW_FLOW_CREDIT = 4'h6;
    localparam logic [3:0]  CW_ACK         = 4'h7;
    localparam logic [3:0]  CW_NACK        = 4'h8;
    localparam logic [3:0]  CW_NO_SPACE    = 4'h9;
    localparam logic [3:0]  CW_RETRY       = 4'hA;

    // ------------------------------------------------------------------
    // Word class codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  WCLS_NONE = 2'h0;
    localparam logic [1:0]  WCLS_DATA = 2'h1;
    localparam logic [1:0]  WCLS_BCST = 2'h2;
    localparam logic [1:0]  WCLS_IDLE = 2'h3;

    typedef enum logic [4:0] {
        NO_FRAME_STATE                 = 5'b00001,
        DATA_FRAME_STATE               = 5'b00010,
        BROADCAST_FRAME_STATE          = 5'b00100,
        NESTED_BROADCAST_IN_DATA_STATE = 5'b01000,
        IDLE_FRAME_STATE               = 5'b10000
    } rxfwi_state_t;

endpackage

// ==== verif/rxfwi_ident_properties.sv ====
// Concurrent property checker of the receive frame word identifier
`timescale 1ns/1ps
module rxfwi_ident_chk
    import rxfwi_pkg::*;
(
    input wire logic              I_REF_CLK,
    input wire logic              I_RST_B,
    input wire logic              i_cold_rst,
    input wire logic              i_warm_rst,
    input wire logic              i_remote_flush,
    input wire logic              i_word_valid,
    input wire logic              i_ctrl_valid,
    input wire logic [3:0]        i_ctrl_type,
    input wire logic [SEQ_W-1:0]  i_ctrl_seq_cnt,
    input wire logic              i_ctrl_seq_pol,
    input wire logic              i_crc_err,
    input wire logic              i_receive_error_indication,
    input wire logic [SEQ_W-1:0]  i_rx_seq_cnt,
    input wire logic              i_rx_seq_pol,
    input wire logic              i_dfrm_ready,
    input wire logic              o_word_valid,
    input wire logic [1:0]        o_word_class,
    input wire logic              o_seq_err,
    input wire logic              o_dfrm_valid,
    input wire logic [DATA_W-1:0] o_dfrm_data,
    input wire logic              o_dfrm_last,
    input wire logic              o_bcst_valid,
    input wire logic              o_credit_valid,
    input wire logic [SEQ_W-1:0]  o_credit_seq_cnt,
    input wire logic              o_ctrl_accept,
    input wire logic [3:0]        o_ctrl_type
);
    wire clean   = !i_receive_error_indication && !i_crc_err;
    wire seq_ok  = (i_ctrl_seq_cnt == i_rx_seq_cnt + SEQ_ONE) && (i_ctrl_seq_pol == i_rx_seq_pol);
    wire acc_w   = i_ctrl_valid && (i_ctrl_type inside {CW_ACK, CW_NACK, CW_NO_SPACE, CW_RETRY});
    wire seq_w   = i_ctrl_valid
                   && (i_ctrl_type inside {CW_END_DATA, CW_END_BCST, CW_FLOW_CREDIT});
    wire good_eb = i_ctrl_valid && i_ctrl_type == CW_END_BCST && clean && seq_ok;
    wire good_ed = i_ctrl_valid && i_ctrl_type == CW_END_DATA && clean && seq_ok;
    wire cred_w  = i_ctrl_valid && i_ctrl_type == CW_FLOW_CREDIT && clean && seq_ok;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B || i_cold_rst || i_warm_rst || i_remote_flush);

    sequence s_open(logic [3:0] c);
        i_ctrl_valid && i_ctrl_type == c && !i_word_valid && clean;
    endsequence
    sequence s_word;
        i_word_valid && !i_ctrl_valid && clean;
    endsequence
    property p_cls(logic [3:0] c, logic [1:0] k);
        s_open(CW_RETRY) ##1 s_open(c) ##1 s_word |=> o_word_valid && o_word_class == k;
    endproperty

    AST_WORD_ECHO: assert property (i_word_valid |=> o_word_valid)
        else $error("word not echoed");
    AST_CTRL_ACCEPT: assert property (acc_w |=>
        o_ctrl_accept && o_ctrl_type == $past(i_ctrl_type))
        else $error("control word not accepted");
    AST_CREDIT_FWD: assert property (cred_w |=>
        o_credit_valid && o_credit_seq_cnt == $past(i_ctrl_seq_cnt))
        else $error("credit not forwarded");
    AST_SEQ_BAD: assert property (seq_w && !seq_ok |=>
        o_seq_err && !o_credit_valid && !o_bcst_valid)
        else $error("sequence error missed");
    AST_BCST_CAUSE: assert property (o_bcst_valid |-> $past(good_eb))
        else $error("broadcast without clean end");
    AST_DFRM_CAUSE: assert property ($rose(o_dfrm_valid) |-> $past(good_ed))
        else $error("data frame without clean end");
    AST_DFRM_HOLD: assert property (o_dfrm_valid && !i_dfrm_ready |=>
        o_dfrm_valid && $stable(o_dfrm_data) && $stable(o_dfrm_last))
        else $error("stalled data word changed");
    AST_FLUSH_QUIET: assert property (disable iff (!I_RST_B)
        i_cold_rst || i_warm_rst || i_remote_flush |=> !o_word_valid && !o_bcst_valid)
        else $error("output active after flush");
    AST_CLASS_IDLE: assert property (p_cls(CW_START_IDLE, WCLS_IDLE))
        else $error("idle word misclassified");
    AST_CLASS_DATA: assert property (p_cls(CW_START_DATA, WCLS_DATA))
        else $error("data word misclassified");
    AST_CLASS_BCST: assert property (p_cls(CW_START_BCST, WCLS_BCST))
        else $error("broadcast word misclassified");
    AST_CLASS_NEST: assert property (s_open(CW_RETRY) ##1 s_open(CW_START_DATA)
        ##1 s_open(CW_START_BCST) ##1 s_word |=> o_word_valid && o_word_class == WCLS_BCST)
        else $error("nested word misclassified");
endmodule

bind rxfwi_ident rxfwi_ident_chk u_chk (.*);

// ==== verif/rxfwi_sink.sv ====
// Framing layer sink model that stalls and records data frame words
`timescale 1ns/1ps
module rxfwi_sink
    import rxfwi_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_stall,
    input  wire logic              i_valid,
    input  wire logic [DATA_W-1:0] i_data,
    input  wire logic              i_last,
    output logic                   o_ready
);
    logic [DATA_W:0] got[$];
    logic            tick = 1'b0;
    initial o_ready = 1'b0;
    // Ready drops every other cycle while stalling
    always @(negedge i_clk) begin
        tick    <= ~tick;
        o_ready <= ~(i_stall & tick);
    end
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            got.push_back({i_last, i_data});
        end
    end
endmodule

// ==== verif/tb_rxfwi_ident.sv ====
// Self-checking testbench of the receive frame word identifier
`timescale 1ns/1ps
module tb_rxfwi_ident
    import rxfwi_pkg::*;
;
    localparam logic [32:0] NIL = {1'b0, 32'h0000_0000};
    logic I_REF_CLK = 1'b0, I_RST_B = 1'b0, i_cold_rst = 1'b0, i_warm_rst = 1'b0;
    logic i_remote_flush = 1'b0, i_word_valid = 1'b0, i_ctrl_valid = 1'b0, i_crc_err = 1'b0;
    logic i_receive_error_indication = 1'b0, i_rx_seq_pol = 1'b0, i_ctrl_seq_pol = 1'b0;
    logic i_dfrm_ready, i_stall = 1'b0;
    logic [DATA_W-1:0] i_word_data = 32'h0000_0000;
    logic [3:0]        i_ctrl_type = 4'h0;
    logic [SEQ_W-1:0]  i_ctrl_seq_cnt = 7'h11, i_rx_seq_cnt = 7'h10;
    logic o_word_valid, o_seq_err, o_dfrm_valid, o_dfrm_last, o_bcst_valid, o_credit_valid;
    logic o_ctrl_accept;
    logic [1:0]        o_word_class;
    logic [3:0]        o_ctrl_type;
    logic [SEQ_W-1:0]  o_credit_seq_cnt;
    logic [DATA_W-1:0] o_dfrm_data, o_bcst_data0, o_bcst_data1;
    int n_errors = 0, checks = 0;

    always #5 I_REF_CLK = ~I_REF_CLK;

    rxfwi_ident u_rxfwi_ident (.*);
    rxfwi_sink u_rxfwi_sink (.i_clk(I_REF_CLK), .i_stall(i_stall), .i_valid(o_dfrm_valid),
        .i_data(o_dfrm_data), .i_last(o_dfrm_last), .o_ready(i_dfrm_ready));

    task automatic finish_test;
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // After the reset wait every step of time passes here, so held valids never repeat a word
    task automatic drv(input logic cv, input logic [3:0] ct,
                       input logic wv, input logic [31:0] wd);
        i_ctrl_valid = cv;
        i_ctrl_type  = ct;
        i_word_valid = wv;
        i_word_data  = wd;
        @(negedge I_REF_CLK);
    endtask
    task automatic ctl(input logic [3:0] ct);
        drv(1'b1, ct, 1'b0, 32'h0000_0000);
    endtask
    task automatic wcls(input logic [31:0] wd, input logic [1:0] k);
        drv(1'b0, 4'h0, 1'b1, wd);
        cmp({o_word_valid, o_word_class}, {1'b1, k});
    endtask
    task automatic got_frame(input int n, input logic [32:0] e0, input logic [32:0] e1);
        repeat (12) drv(1'b0, 4'h0, 1'b0, 32'h0000_0000);
        cmp(u_rxfwi_sink.got.size(), n);
        if (n > 0) cmp(u_rxfwi_sink.got[0], e0);
        if (n > 1) cmp(u_rxfwi_sink.got[1], e1);
        u_rxfwi_sink.got.delete();
    endtask

    task automatic t_data;
        i_stall = 1'b1;
        ctl(CW_RETRY);
        ctl(CW_START_DATA);
        wcls(32'hA5A5_0001, WCLS_DATA);
        wcls(32'hA5A5_0002, WCLS_DATA);
        ctl(CW_END_DATA);
        got_frame(2, {1'b0, 32'hA5A5_0001}, {1'b1, 32'hA5A5_0002});
        i_stall = 1'b0;
        ctl(CW_START_DATA);
        ctl(CW_END_DATA);
        got_frame(0, NIL, NIL);
        ctl(CW_START_DATA);
        wcls(32'hA5A5_0003, WCLS_DATA);
        repeat (2) ctl(CW_START_DATA);
        wcls(32'hA5A5_0004, WCLS_DATA);
        ctl(CW_END_DATA);
        got_frame(1, {1'b1, 32'hA5A5_0004}, NIL);
        ctl(CW_START_DATA);
        repeat (65) wcls(32'hA5A5_0005, WCLS_DATA);
        ctl(CW_END_DATA);
        got_frame(0, NIL, NIL);
    endtask
    task automatic t_bcst;
        ctl(CW_RETRY);
        for (int n = 1; n <= 3; n += 2) begin
            ctl(CW_START_BCST);
            repeat (n) wcls(32'hB0B0_0002, WCLS_BCST);
            ctl(CW_END_BCST);
            cmp(o_bcst_valid, 1'b0);
        end
        ctl(CW_START_BCST);
        wcls(32'hB0B0_0000, WCLS_BCST);
        wcls(32'hB0B0_0001, WCLS_BCST);
        ctl(CW_END_BCST);
        cmp({o_bcst_valid, o_bcst_data0}, {1'b1, 32'hB0B0_0000});
        cmp(o_bcst_data1, 32'hB0B0_0001);
    endtask
    task automatic t_nest;
        ctl(CW_START_DATA);
        wcls(32'hC0C0_0001, WCLS_DATA);
        ctl(CW_START_BCST);
        wcls(32'hC0C0_0B00, WCLS_BCST);
        wcls(32'hC0C0_0B01, WCLS_BCST);
        ctl(CW_END_BCST);
        cmp({o_bcst_valid, o_bcst_data1}, {1'b1, 32'hC0C0_0B01});
        wcls(32'hC0C0_0002, WCLS_DATA);
        ctl(CW_END_DATA);
        got_frame(2, {1'b0, 32'hC0C0_0001}, {1'b1, 32'hC0C0_0002});
        ctl(CW_RETRY);
        ctl(CW_START_DATA);
        ctl(CW_START_BCST);
        wcls(32'hC0C0_0B02, WCLS_BCST);
        ctl(CW_END_BCST);
        wcls(32'hC0C0_0003, WCLS_NONE);
        ctl(CW_END_DATA);
        got_frame(0, NIL, NIL);
    endtask
    task automatic t_errors;
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 4; k++) begin
                ctl(CW_RETRY);
                if (s > 0) ctl(CW_START_DATA);
                if (s != 1) ctl(CW_START_BCST);
                wcls(32'hE000_0000, (s == 1) ? WCLS_DATA : WCLS_BCST);
                wcls(32'hE000_0001, (s == 1) ? WCLS_DATA : WCLS_BCST);
                i_receive_error_indication = (k == 1);
                i_crc_err = (k == 2);
                i_ctrl_seq_pol = (k == 3);
                ctl((k == 0) ? CW_RETRY : (s == 1) ? CW_END_DATA : CW_END_BCST);
                cmp({o_seq_err, o_bcst_valid}, {k == 3, 1'b0});
                i_receive_error_indication = 1'b0;
                i_crc_err = 1'b0;
                i_ctrl_seq_pol = 1'b0;
                wcls(32'hE000_0002, WCLS_NONE);
                ctl(CW_END_DATA);
                got_frame(0, NIL, NIL);
            end
        end
    endtask
    task automatic t_idle;
        ctl(CW_RETRY);
        ctl(CW_START_IDLE);
        wcls(32'h1D1E_0000, WCLS_IDLE);
        ctl(CW_START_IDLE);
        wcls(32'h1D1E_0001, WCLS_IDLE);
        ctl(CW_START_BCST);
        wcls(32'h1D1E_0002, WCLS_BCST);
        ctl(CW_RETRY);
        ctl(CW_START_IDLE);
        ctl(CW_START_DATA);
        wcls(32'h1D1E_0003, WCLS_DATA);
        for (int j = 0; j < 3; j++) begin
            ctl(CW_RETRY);
            ctl(CW_START_IDLE);
            i_receive_error_indication = (j == 2);
            ctl((j == 0) ? CW_END_DATA : (j == 1) ? CW_END_BCST : CW_START_IDLE);
            i_receive_error_indication = 1'b0;
            wcls(32'h1D1E_0004, WCLS_NONE);
        end
    endtask
    task automatic t_frame_err;
        logic [3:0] bad [4] = '{CW_START_DATA, CW_START_BCST, CW_START_IDLE, CW_END_DATA};
        for (int n = 0; n < 2; n++) begin
            for (int i = 0; i < 4; i++) begin
                ctl(CW_RETRY);
                if (n == 1) ctl(CW_START_DATA);
                ctl(CW_START_BCST);
                ctl(bad[i]);
                wcls(32'hF000_0000, WCLS_NONE);
            end
        end
    endtask
    task automatic t_ctrl;
        logic [3:0] cw [5] = '{CW_ACK, CW_NACK, CW_NO_SPACE, CW_RETRY, CW_FLOW_CREDIT};
        logic [3:0] op [4] = '{CW_RETRY, CW_START_DATA, CW_START_BCST, CW_START_IDLE};
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 5; c++) begin
                ctl(CW_RETRY);
                ctl(op[s]);
                ctl(cw[c]);
                if (c < 4) cmp({o_ctrl_accept, o_ctrl_type}, {1'b1, cw[c]});
                else cmp({o_credit_valid, o_credit_seq_cnt}, {1'b1, 7'h11});
            end
        end
        i_rx_seq_cnt = 7'h7F;
        i_ctrl_seq_cnt = 7'h00;
        ctl(CW_FLOW_CREDIT);
        cmp({o_credit_valid, o_credit_seq_cnt}, {1'b1, 7'h00});
        i_ctrl_seq_pol = 1'b1;
        ctl(CW_FLOW_CREDIT);
        cmp({o_credit_valid, o_seq_err}, 2'b01);
        i_ctrl_seq_cnt = 7'h01;
        i_ctrl_seq_pol = 1'b0;
        ctl(CW_FLOW_CREDIT);
        cmp({o_credit_valid, o_seq_err}, 2'b01);
        i_rx_seq_cnt = 7'h10;
        i_ctrl_seq_cnt = 7'h11;
    endtask
    task automatic t_flush;
        for (int f = 0; f < 3; f++) begin
            ctl(CW_RETRY);
            ctl(CW_START_DATA);
            wcls(32'hF1F1_0000, WCLS_DATA);
            {i_cold_rst, i_warm_rst, i_remote_flush} = 3'h4 >> f;
            drv(1'b0, 4'h0, 1'b0, 32'h0000_0000);
            {i_cold_rst, i_warm_rst, i_remote_flush} = 3'h0;
            ctl(CW_END_DATA);
            got_frame(0, NIL, NIL);
            ctl(CW_START_BCST);
            wcls(32'hF1F1_0B00, WCLS_BCST);
            {i_cold_rst, i_warm_rst, i_remote_flush} = 3'h4 >> f;
            drv(1'b0, 4'h0, 1'b0, 32'h0000_0000);
            {i_cold_rst, i_warm_rst, i_remote_flush} = 3'h0;
            wcls(32'hF1F1_0B01, WCLS_NONE);
            ctl(CW_END_BCST);
            cmp(o_bcst_valid, 1'b0);
        end
    endtask

    initial begin
        repeat (12) @(negedge I_REF_CLK);
        I_RST_B = 1'b1;
        t_data();
        t_bcst();
        t_nest();
        t_errors();
        t_idle();
        t_frame_err();
        t_ctrl();
        t_flush();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge I_REF_CLK);
        n_errors++;
        finish_test();
    end
endmodule
